// file: hw/audio_amp_ctrl_status_regs.sv
// Control/status register bank of a digital audio amplifier
// Function
// - Status bits 7..5 show detected sample rate; codes 001, 010 unused.
// - Status bits 4..2 show detected master clock ratio; bits 1..0 zero.
// - Low ratios only allowed at listed sample rates.
// - Clock rates detected without host help, shown read-only at 0x00.
// - Offset 0x01 is a fixed read-only revision identity byte.
// - Error bits latch, hardware never clears them, reset to zero.
// - Error bit order: mclk, pll, bit clk, frame clk, eq, drc, power, dc.
// - Master clock count per frame changing raises master clock error.
// - Bit clock count per frame changing raises bit clock error.
// - Frame clock period change beyond tolerance raises frame clock error.
// - Dc flag sets only when dc detect enabled and dc seen.
// - Control one bit 7 enables dc-blocking filter, on at reset.
// - Control one bit 5 picks hard (default) or soft unmute.
// - Control one bits 1..0 select de-emphasis, none at reset.
// - Format register low nibble selects serial format, default 0101.
// - Control two bit 6 holds shutdown, set at reset.
// - Control two bit 4 headphone mode, bit 3 volume source.
// - Control two bit 1 makes shared pin an output.
// - Control two bit 0 picks shared pin source; host sets before mode.
// - Registers reached by 8-bit subaddress over the serial control bus.
`timescale 1ns/1ps
`include "amp_ctrl_defines.svh"

module audio_amp_ctrl_status_regs #(
    parameter logic [6:0] DEV_ADDR_BASE    = 7'h1a, // Arbitrary value
    parameter logic [7:0] REVISION_ID      = 8'h5a, // Arbitrary value
    parameter int         RATE_EDGE_8K_CNT = `AMP_RATE_EDGE_8K_CNT
) (
    // System clock and reset
    input  wire logic                   clk,
    input  wire logic                   reset,
    // Serial control bus pins
    input  wire logic                   sclIn,
    input  wire logic                   sdaIn,
    output logic                        sdaOut,
    output logic                        sdaOe,
    // Shared address-select / headphone-shutdown pin
    input  wire logic                   addrselHpoffPinIn,
    output logic                        addrselHpoffPinOut,
    output logic                        addrselHpoffPinOe,
    // Audio clocks
    input  wire logic                   mclk,
    input  wire logic                   sclk,
    input  wire logic                   lrclk,
    // Error sources from the datapath
    input  wire logic                   pllUnlock,
    input  wire logic                   equalizerFlag,
    input  wire logic                   dynamicRangeCtrlFlag,
    input  wire logic                   powerFault,
    input  wire logic                   dcDetectEn,
    input  wire logic                   dcDetect,
    // Control outputs
    output amp_ctrl_pkg::reg_byte_t     sysCtrlOne,
    output amp_ctrl_pkg::reg_byte_t     serialFormat,
    output amp_ctrl_pkg::reg_byte_t     sysCtrlTwo,
    output logic                        headphoneShutdownN
);
    import amp_ctrl_pkg::*;

    ctl_state_t state_reg;
    reg_byte_t  errFlags_reg, ctrl1_reg, format_reg, ctrl2_reg;
    reg_byte_t  shift_reg, ptr_reg, wrData;
    logic [3:0] bitCnt_reg;
    logic [2:0] rate_reg, ratio_reg;
    logic       sdaLow_reg, rwBit_reg, ackN_reg, wrEn, addrLsb_reg;
    logic       strapDone_reg;
    logic       scl1, scl2, sclPrev, sda1, sda2, sdaPrev;
    logic       pin1, pin2, lr1, lr2, lrPrev, sck1, sck2, sckPrev;

    function automatic reg_byte_t readMux(input reg_byte_t a);
        unique case (a)
            `AMP_OFS_CLK_STATUS: readMux = {rate_reg, ratio_reg, 2'b00};
            `AMP_OFS_REVISION:   readMux = REVISION_ID;
            `AMP_OFS_ERR_FLAGS:  readMux = errFlags_reg;
            `AMP_OFS_SYS_CTRL1:  readMux = ctrl1_reg;
            `AMP_OFS_SER_FORMAT: readMux = format_reg;
            `AMP_OFS_SYS_CTRL2:  readMux = ctrl2_reg;
            default:             readMux = 8'h00;
        endcase
    endfunction : readMux

    function automatic logic [2:0] ratioCode(input logic [9:0] c);
        if (c < 10'h060)      ratioCode = 3'h0;
        else if (c < 10'h0a0) ratioCode = 3'h1;
        else if (c < 10'h0e0) ratioCode = 3'h2;
        else if (c < 10'h140) ratioCode = 3'h3;
        else if (c < 10'h1c0) ratioCode = 3'h4;
        else if (c < 10'h280) ratioCode = 3'h5;
        else                  ratioCode = 3'h7;
    endfunction : ratioCode

    // Read bytes at and after the pointer
    reg_byte_t rdCur, rdNext;
    always_comb
    begin
        rdCur  = readMux(ptr_reg);
        rdNext = readMux(ptr_reg + 8'h01);
    end

    // Pin synchronisers
    always_ff @(posedge clk)
    begin
        scl1 <= sclIn;   scl2 <= scl1;   sclPrev <= scl2;
        sda1 <= sdaIn;   sda2 <= sda1;   sdaPrev <= sda2;
        pin1 <= addrselHpoffPinIn;   pin2 <= pin1;
        lr1 <= lrclk;    lr2 <= lr1;     lrPrev <= lr2;
        sck1 <= sclk;    sck2 <= sck1;   sckPrev <= sck2;
    end

    wire sclRise  = scl2 & ~sclPrev;
    wire sclFall  = ~scl2 & sclPrev;
    wire startCnd = scl2 & sclPrev & ~sda2 & sdaPrev;
    wire stopCnd  = scl2 & sclPrev & sda2 & ~sdaPrev;
    wire addrHit  = shift_reg[7:1] == {DEV_ADDR_BASE[6:1], addrLsb_reg};

    // Address strap caught after reset release
    always_ff @(posedge clk)
    begin
        if (reset)
            strapDone_reg <= 1'b0;
        else if (!strapDone_reg)
        begin
            addrLsb_reg   <= pin2;
            strapDone_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk)
    begin
        wrEn <= 1'b0;
        if (reset)
        begin
            state_reg  <= ST_IDLE;
            sdaLow_reg <= 1'b0;
            bitCnt_reg <= 4'h0;
            shift_reg  <= 8'h00;
            ptr_reg    <= 8'h00;
            rwBit_reg  <= 1'b0;
            ackN_reg   <= 1'b1;
            wrData     <= 8'h00;
        end
        else if (startCnd)
        begin
            state_reg  <= ST_ADDR;
            bitCnt_reg <= 4'h0;
            sdaLow_reg <= 1'b0;
        end
        else if (stopCnd)
        begin
            state_reg  <= ST_IDLE;
            sdaLow_reg <= 1'b0;
        end
        else if (sclRise)
        begin
            if (state_reg inside {ST_ADDR, ST_SUB, ST_WDATA})
                shift_reg <= {shift_reg[6:0], sda2};
            if (state_reg == ST_RACK)
                ackN_reg <= sda2;
            bitCnt_reg <= bitCnt_reg + 4'h1;
        end
        else if (sclFall)
        begin
            unique case (state_reg)
                ST_IDLE: ;
                ST_ADDR:
                    if (bitCnt_reg == 4'h8)
                    begin
                        state_reg  <= addrHit ? ST_ADDRACK : ST_IDLE;
                        sdaLow_reg <= addrHit;
                        rwBit_reg  <= shift_reg[0];
                    end
                ST_ADDRACK:
                begin
                    bitCnt_reg <= 4'h0;
                    if (rwBit_reg)
                    begin
                        state_reg  <= ST_RDATA;
                        shift_reg  <= readMux(ptr_reg);
                        sdaLow_reg <= ~rdCur[7];
                    end
                    else
                    begin
                        state_reg  <= ST_SUB;
                        sdaLow_reg <= 1'b0;
                    end
                end
                ST_SUB:
                    if (bitCnt_reg == 4'h8)
                    begin
                        ptr_reg    <= shift_reg;
                        sdaLow_reg <= 1'b1;
                        state_reg  <= ST_SUBACK;
                    end
                ST_SUBACK, ST_WACK:
                begin
                    sdaLow_reg <= 1'b0;
                    bitCnt_reg <= 4'h0;
                    state_reg  <= ST_WDATA;
                    if (state_reg == ST_WACK)
                        ptr_reg <= ptr_reg + 8'h01;
                end
                ST_WDATA:
                    if (bitCnt_reg == 4'h8)
                    begin
                        wrEn       <= 1'b1;
                        wrData     <= shift_reg;
                        sdaLow_reg <= 1'b1;
                        state_reg  <= ST_WACK;
                    end
                ST_RDATA:
                    if (bitCnt_reg == 4'h8)
                    begin
                        sdaLow_reg <= 1'b0;
                        state_reg  <= ST_RACK;
                    end
                    else
                        sdaLow_reg <= ~shift_reg[3'h7 - bitCnt_reg[2:0]];
                ST_RACK:
                begin
                    bitCnt_reg <= 4'h0;
                    ptr_reg    <= ptr_reg + 8'h01;
                    shift_reg  <= readMux(ptr_reg + 8'h01);
                    sdaLow_reg <= ~ackN_reg & ~rdNext[7];
                    state_reg  <= ackN_reg ? ST_IDLE : ST_RDATA;
                end
            endcase
        end
    end

    assign sdaOut = 1'b0;
    assign sdaOe  = sdaLow_reg;

    // Master clock domain: reset synchroniser and frame measurement
    logic       mRstMeta, mRst, lrM1, lrM2, lrM3, mUpdTgl, mErrTgl;
    logic [1:0] mSeen;
    logic [9:0] mCnt, mWord;

    always_ff @(posedge mclk)
    begin
        mRstMeta <= reset;
        mRst     <= mRstMeta;
        lrM1     <= lrclk;
        lrM2     <= lrM1;
        lrM3     <= lrM2;
    end

    always_ff @(posedge mclk)
    begin
        if (mRst)
        begin
            mCnt    <= 10'h000;
            mWord   <= 10'h000;
            mUpdTgl <= 1'b0;
            mErrTgl <= 1'b0;
            mSeen   <= 2'b00;
        end
        else if (lrM2 & ~lrM3)
        begin
            mCnt    <= 10'h001;
            mWord   <= mCnt;
            mUpdTgl <= ~mUpdTgl;
            mSeen   <= {mSeen[0], 1'b1};
            if (mSeen[1] && mCnt != mWord)
                mErrTgl <= ~mErrTgl;
        end
        else if (mCnt != 10'h3ff)
            mCnt <= mCnt + 10'h001;
    end

    // Toggle crossings into the system clock
    logic updS1, updS2, updPrev, errS1, errS2, errPrev;
    always_ff @(posedge clk)
    begin
        updS1 <= mUpdTgl;  updS2 <= updS1;  updPrev <= updS2;
        errS1 <= mErrTgl;  errS2 <= errS1;  errPrev <= errS2;
    end
    // Mclk side leaves reset later; its toggles are ignored until then
    logic [3:0] xingWait_reg;
    always_ff @(posedge clk)
    begin
        if (reset)
            xingWait_reg <= `AMP_XING_SETTLE_CNT;
        else if (xingWait_reg != 4'h0)
            xingWait_reg <= xingWait_reg - 4'h1;
    end
    wire xingReady  = xingWait_reg == 4'h0;
    wire mclkChange = xingReady & (errS2 ^ errPrev);

    // ratio code follows settled master count
    always_ff @(posedge clk)
    begin
        if (reset)
            ratio_reg <= 3'h3;
        else if (xingReady && (updS2 ^ updPrev))
            ratio_reg <= ratioCode(mWord);
    end

    // Frame period and bit clock counts on the system clock
    logic [15:0] lrCnt, lrPeriod;
    logic [9:0]  sckCnt, sckWord;
    logic [1:0]  lrSeen;
    logic        lrChange, sckChange;
    wire         lrRise = lr2 & ~lrPrev;

    always_ff @(posedge clk)
    begin
        lrChange  <= 1'b0;
        sckChange <= 1'b0;
        if (reset)
        begin
            lrCnt    <= 16'h0000;
            lrPeriod <= 16'h0000;
            sckCnt   <= 10'h000;
            sckWord  <= 10'h000;
            lrSeen   <= 2'b00;
        end
        else if (lrRise)
        begin
            lrCnt    <= 16'h0001;
            lrPeriod <= lrCnt;
            sckCnt   <= 10'h000;
            sckWord  <= sckCnt + {9'h000, sck2 & ~sckPrev};
            lrSeen   <= {lrSeen[0], 1'b1};
            if (lrSeen[1])
            begin
                lrChange  <= (lrCnt > lrPeriod + `AMP_LR_TOL_CNT)
                          || (lrCnt + `AMP_LR_TOL_CNT < lrPeriod);
                sckChange <= (sckCnt + {9'h000, sck2 & ~sckPrev})
                          != sckWord;
            end
        end
        else
        begin
            if (lrCnt != 16'hffff)
                lrCnt <= lrCnt + 16'h0001;
            if ((sck2 & ~sckPrev) && sckCnt != 10'h3ff)
                sckCnt <= sckCnt + 10'h001;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            rate_reg <= `AMP_RATE_48K;
        else if (lrRise && lrSeen[1])
        begin
            if (lrCnt > 16'(RATE_EDGE_8K_CNT))
                rate_reg <= `AMP_RATE_8K;
            else if (lrCnt > 16'(`AMP_RATE_EDGE_12K_CNT))
                rate_reg <= `AMP_RATE_12K;
            else if (lrCnt > 16'(`AMP_RATE_EDGE_16K_CNT))
                rate_reg <= `AMP_RATE_16K;
            else if (lrCnt > 16'(`AMP_RATE_EDGE_24K_CNT))
                rate_reg <= `AMP_RATE_24K;
            else if (lrCnt > 16'(`AMP_RATE_EDGE_32K_CNT))
                rate_reg <= `AMP_RATE_32K;
            else
                rate_reg <= `AMP_RATE_48K;
        end
    end

    logic ratioBad;
    always_comb
    begin
        unique case (ratio_reg)
            3'h0, 3'h1: ratioBad = rate_reg != `AMP_RATE_48K;
            3'h2:       ratioBad = rate_reg != `AMP_RATE_48K
                                && rate_reg != `AMP_RATE_32K;
            3'h3:       ratioBad = rate_reg == `AMP_RATE_8K;
            default:    ratioBad = 1'b0;
        endcase
    end

    reg_byte_t errEvent;
    assign errEvent = {mclkChange | ratioBad, pllUnlock, sckChange,
                       lrChange, equalizerFlag, dynamicRangeCtrlFlag,
                       powerFault, dcDetect & dcDetectEn};

    always_ff @(posedge clk)
    begin
        if (reset)
            errFlags_reg <= `AMP_RST_ERR_FLAGS;
        else if (wrEn && ptr_reg == `AMP_OFS_ERR_FLAGS)
            errFlags_reg <= (errFlags_reg & wrData) | errEvent;
        else
            errFlags_reg <= errFlags_reg | errEvent;
    end

    // status and identity take no writes
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            ctrl1_reg  <= `AMP_RST_SYS_CTRL1;
            format_reg <= `AMP_RST_SER_FORMAT;
            ctrl2_reg  <= `AMP_RST_SYS_CTRL2;
        end
        else if (wrEn)
        begin
            if (ptr_reg == `AMP_OFS_SYS_CTRL1)
                ctrl1_reg <= wrData;
            if (ptr_reg == `AMP_OFS_SER_FORMAT)
                format_reg <= wrData;
            if (ptr_reg == `AMP_OFS_SYS_CTRL2)
                ctrl2_reg <= wrData;
        end
    end

    assign sysCtrlOne   = ctrl1_reg;
    assign serialFormat = format_reg;
    assign sysCtrlTwo   = ctrl2_reg;
    assign headphoneShutdownN = ctrl2_reg[`AMP_BIT_HP_MODE]
                              & ~ctrl2_reg[`AMP_BIT_SHUTDOWN];

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            addrselHpoffPinOe  <= 1'b0;
            addrselHpoffPinOut <= 1'b0;
        end
        else
        begin
            addrselHpoffPinOe  <= ctrl2_reg[`AMP_BIT_PIN_OUT];
            addrselHpoffPinOut <= ctrl2_reg[`AMP_BIT_PIN_SRC]
                                ? headphoneShutdownN : ~powerFault;
        end
    end

    sequence ctrl2WriteSeq;
        wrEn && ptr_reg == `AMP_OFS_SYS_CTRL2;
    endsequence

    errSticky_a: assert property (@(posedge clk) disable iff (reset)
        !(wrEn && ptr_reg == `AMP_OFS_ERR_FLAGS) |=>
            (errFlags_reg & $past(errFlags_reg)) == $past(errFlags_reg))
        else $error("error flag dropped without a clear");
    dcGate_a: assert property (@(posedge clk) disable iff (reset)
        $rose(errFlags_reg[`AMP_ERR_DC]) |->
            $past(dcDetect && dcDetectEn))
        else $error("dc flag set without enabled detection");
    sclkErr_a: assert property (@(posedge clk) disable iff (reset)
        sckChange |=> errFlags_reg[`AMP_ERR_SCLK])
        else $error("bit clock change not latched");
    statusHold_a: assert property (@(posedge clk) disable iff (reset)
        !(updS2 ^ updPrev) && !lrRise |=> $stable({rate_reg, ratio_reg}))
        else $error("status moved without detection");
    rateCode_a: assert property (@(posedge clk) disable iff (reset)
        rate_reg != 3'h1 && rate_reg != 3'h2)
        else $error("reserved rate code shown");
    shutdownWr_a: assert property (@(posedge clk) disable iff (reset)
        ctrl2WriteSeq |=> sysCtrlTwo[6] == $past(wrData[6]))
        else $error("shutdown bit not taken");
    pinDir_a: assert property (@(posedge clk) disable iff (reset)
        ctrl2WriteSeq ##1 1'b1 |=> addrselHpoffPinOe == $past(wrData[1], 2))
        else $error("shared pin direction wrong");
    ctrlReset_a: assert property (@(posedge clk)
        $past(reset) && !reset |-> sysCtrlOne == 8'ha0
            && serialFormat == 8'h05 && sysCtrlTwo[6])
        else $error("control reset values wrong");
    idRead_a: assert property (@(posedge clk) disable iff (reset)
        state_reg == ST_ADDRACK && sclFall && rwBit_reg
            && ptr_reg == 8'h01 |=> shift_reg == REVISION_ID)
        else $error("identity byte not loaded");

endmodule : audio_amp_ctrl_status_regs

// file: pkg/amp_ctrl_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef AMP_CTRL_DEFINES_SVH
`define AMP_CTRL_DEFINES_SVH

`define AMP_OFS_CLK_STATUS   8'h00
`define AMP_OFS_REVISION     8'h01
`define AMP_OFS_ERR_FLAGS    8'h02
`define AMP_OFS_SYS_CTRL1    8'h03
`define AMP_OFS_SER_FORMAT   8'h04
`define AMP_OFS_SYS_CTRL2    8'h05

`define AMP_RST_ERR_FLAGS    8'h00
`define AMP_RST_SYS_CTRL1    8'ha0
`define AMP_RST_SER_FORMAT   8'h05
`define AMP_RST_SYS_CTRL2    8'h40

`define AMP_BIT_DC_BLOCK     7
`define AMP_BIT_HARD_UNMUTE  5
`define AMP_BIT_SHUTDOWN     6
`define AMP_BIT_HP_MODE      4
`define AMP_BIT_HP_VOL_SRC   3
`define AMP_BIT_PIN_OUT      1
`define AMP_BIT_PIN_SRC      0

`define AMP_ERR_MCLK         7
`define AMP_ERR_PLL          6
`define AMP_ERR_SCLK         5
`define AMP_ERR_LRCLK        4
`define AMP_ERR_EQ           3
`define AMP_ERR_DRC          2
`define AMP_ERR_POWER        1
`define AMP_ERR_DC           0

`define AMP_RATE_32K         3'h0
`define AMP_RATE_48K         3'h3
`define AMP_RATE_16K         3'h4
`define AMP_RATE_24K         3'h5
`define AMP_RATE_8K          3'h6
`define AMP_RATE_12K         3'h7

`define AMP_CLK_HZ           50000000
`define AMP_EDGE_8K_HZ       9300
`define AMP_EDGE_12K_HZ      13500
`define AMP_EDGE_16K_HZ      19000
`define AMP_EDGE_24K_HZ      27500
`define AMP_EDGE_32K_HZ      38500
`define AMP_RATE_EDGE_8K_CNT  (`AMP_CLK_HZ / `AMP_EDGE_8K_HZ)
`define AMP_RATE_EDGE_12K_CNT (`AMP_CLK_HZ / `AMP_EDGE_12K_HZ)
`define AMP_RATE_EDGE_16K_CNT (`AMP_CLK_HZ / `AMP_EDGE_16K_HZ)
`define AMP_RATE_EDGE_24K_CNT (`AMP_CLK_HZ / `AMP_EDGE_24K_HZ)
`define AMP_RATE_EDGE_32K_CNT (`AMP_CLK_HZ / `AMP_EDGE_32K_HZ)
`define AMP_LR_TOL_CNT       16'h0004
`define AMP_XING_SETTLE_CNT  4'hf

`endif

// file: pkg/amp_ctrl_pkg.sv
// Types shared by the amplifier control register bank
package amp_ctrl_pkg;

    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_ADDR    = 9'h002,
        ST_ADDRACK = 9'h004,
        ST_SUB     = 9'h008,
        ST_SUBACK  = 9'h010,
        ST_WDATA   = 9'h020,
        ST_WACK    = 9'h040,
        ST_RDATA   = 9'h080,
        ST_RACK    = 9'h100
    } ctl_state_t;

    typedef logic [7:0] reg_byte_t;

endpackage : amp_ctrl_pkg

// file: verif/i2c_host_model.sv
// Host model driving the serial control bus
`timescale 1ns/1ps
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h1a
) (
    // Clock
    input  wire logic clk,
    // Bus pins, a released line reads high
    output logic      scl,
    output logic      sdaPull,
    input  wire logic sda
);
    import amp_ctrl_pkg::*;
    initial
    begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    // Data moves only while the clock is low
    task automatic bitIo(input logic b, output logic r);
        scl = 1'b0;
        w(3);
        sdaPull = ~b;
        w(6);
        scl = 1'b1;
        w(6);
        r = sda;
    endtask : bitIo
    // Start when st is 1, stop when 0
    task automatic cond(input logic st);
        scl = 1'b0;
        w(3);
        sdaPull = ~st;
        w(6);
        scl = 1'b1;
        w(6);
        sdaPull = st;
        w(6);
    endtask : cond
    task automatic xfer(input reg_byte_t tx, input logic ackIn,
                        output reg_byte_t rx, output logic nak);
        for (int i = 7; i >= 0; i--)
            bitIo(tx[i], rx[i]);
        bitIo(ackIn, nak);
    endtask : xfer
    task automatic writeReg(input reg_byte_t sub, input reg_byte_t d,
                            output logic ok);
        reg_byte_t rx;
        logic      n0, n1, n2;
        cond(1'b1);
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, n0);
        xfer(sub, 1'b1, rx, n1);
        xfer(d, 1'b1, rx, n2);
        cond(1'b0);
        ok = !(n0 | n1 | n2);
    endtask : writeReg
    task automatic readReg(input reg_byte_t sub, output reg_byte_t d,
                           output logic ok);
        reg_byte_t rx;
        logic      n0, n1, n2, n3;
        cond(1'b1);
        xfer({DEV_ADDR, 1'b0}, 1'b1, rx, n0);
        xfer(sub, 1'b1, rx, n1);
        cond(1'b1);
        xfer({DEV_ADDR, 1'b1}, 1'b1, rx, n2);
        xfer(8'hff, 1'b1, d, n3);
        cond(1'b0);
        ok = !(n0 | n1 | n2);
    endtask : readReg
endmodule : i2c_host_model

// file: verif/audio_amp_ctrl_status_regs_tb_top.sv
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ps
module audio_amp_ctrl_status_regs_tb_top;
    import amp_ctrl_pkg::*;
    localparam reg_byte_t REV = 8'h5a; // Arbitrary value
    logic      clk, reset, mclk, scl, sdaPull, sdaOe, sdaOut, pinOut, pinOe;
    logic      pllUnlock, eqFlag, drcFlag, powerFault, dcDetectEn, dcDetect;
    logic      hpOffN;
    reg_byte_t ctrlOne, fmt, ctrlTwo;
    int        mcnt = 0, ratio = 512, nextRatio = 512, sckDiv = 128;
    int        errCount = 0, compares = 0;
    wire       sda = ~(sdaOe | sdaPull);
    wire       pinIn = pinOe & pinOut;
    wire       lrclk = mcnt < ratio / 2;
    wire       sclk = (mcnt / (ratio / sckDiv)) % 2 == 1;
    audio_amp_ctrl_status_regs #(
        .REVISION_ID(REV)
    ) u_audio_amp_ctrl_status_regs (
        .clk(clk), .reset(reset), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .addrselHpoffPinIn(pinIn),
        .addrselHpoffPinOut(pinOut), .addrselHpoffPinOe(pinOe),
        .mclk(mclk), .sclk(sclk), .lrclk(lrclk), .pllUnlock(pllUnlock),
        .equalizerFlag(eqFlag), .dynamicRangeCtrlFlag(drcFlag),
        .powerFault(powerFault), .dcDetectEn(dcDetectEn),
        .dcDetect(dcDetect), .sysCtrlOne(ctrlOne), .serialFormat(fmt),
        .sysCtrlTwo(ctrlTwo), .headphoneShutdownN(hpOffN)
    );
    i2c_host_model u_i2c_host_model (
        .clk(clk), .scl(scl), .sdaPull(sdaPull), .sda(sda)
    );
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial
    begin
        mclk = 1'b0;
        forever #24 mclk = ~mclk;
    end
    // Ratio changes only at a frame boundary
    always @(posedge mclk)
        if (mcnt >= ratio - 1)
        begin
            mcnt <= 0;
            ratio <= nextRatio;
        end
        else
            mcnt <= mcnt + 1;
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic check(input string what, input reg_byte_t exp,
                         input reg_byte_t got);
        compares++;
        if (got !== exp)
        begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic rd(input reg_byte_t sub, input reg_byte_t exp);
        reg_byte_t d;
        logic      ok;
        u_i2c_host_model.readReg(sub, d, ok);
        check("read ack", 8'h01, {7'h00, ok});
        check($sformatf("reg %h", sub), exp, d);
    endtask : rd
    task automatic wr(input reg_byte_t sub, input reg_byte_t d);
        logic ok;
        u_i2c_host_model.writeReg(sub, d, ok);
        check("write ack", 8'h01, {7'h00, ok});
    endtask : wr
    task automatic testReset;
        check("ctrl one", 8'ha0, ctrlOne);
        check("format", 8'h05, fmt);
        check("ctrl two", 8'h40, ctrlTwo);
        check("pin", 8'h01, {5'h00, hpOffN, pinOe, pinOut});
        check("sda value", 8'h00, {7'h00, sdaOut});
        rd(8'h01, REV);
        rd(8'h02, 8'h00);
        rd(8'h03, 8'ha0);
        rd(8'h04, 8'h05);
        rd(8'h05, 8'h40);
    endtask : testReset
    task automatic testStatus;
        cyc(6200);
        rd(8'h00, 8'h74);
        wr(8'h00, 8'h00);
        wr(8'h01, 8'h00);
        rd(8'h00, 8'h74);
        rd(8'h01, REV);
        rd(8'h10, 8'h00);
    endtask : testStatus
    task automatic testControl;
        for (int k = 0; k < 4; k++)
        begin
            wr(8'h03, 8'h80 | k[7:0]);
            check("ctrl one", 8'h80 | k[7:0], ctrlOne);
        end
        wr(8'h03, 8'h00);
        rd(8'h03, 8'h00);
        for (int k = 0; k < 9; k++)
        begin
            wr(8'h04, k[7:0]);
            check("format", k[7:0], fmt);
        end
        wr(8'h05, 8'h01);
        wr(8'h05, 8'h1b);
        check("ctrl two", 8'h1b, ctrlTwo);
        check("pin", 8'h07, {5'h00, hpOffN, pinOe, pinOut});
        wr(8'h05, 8'h02);
        check("pin", 8'h03, {5'h00, hpOffN, pinOe, pinOut});
        powerFault = 1'b1;
        cyc(4);
        check("pin", 8'h02, {5'h00, hpOffN, pinOe, pinOut});
        powerFault = 1'b0;
        wr(8'h05, 8'h53);
        check("pin", 8'h02, {5'h00, hpOffN, pinOe, pinOut});
    endtask : testControl
    task automatic testErrors;
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h00);
        {pllUnlock, eqFlag, drcFlag, powerFault, dcDetect} = 5'h1f;
        cyc(1);
        {pllUnlock, eqFlag, drcFlag, powerFault, dcDetect} = 5'h00;
        rd(8'h02, 8'h4e);
        {dcDetectEn, dcDetect} = 2'h3;
        cyc(1);
        dcDetect = 1'b0;
        rd(8'h02, 8'h4f);
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h00);
    endtask : testErrors
    task automatic testClockChange;
        wr(8'h02, 8'h00);
        rd(8'h02, 8'h00);
        nextRatio = 256;
        cyc(5000);
        rd(8'h02, 8'h90);
        rd(8'h00, 8'h6c);
        rd(8'h02, 8'h90);
        wr(8'h02, 8'h00);
        sckDiv = 64;
        cyc(3000);
        rd(8'h02, 8'h20);
    endtask : testClockChange
    task automatic wrapUp;
        $display("compares %0d errors %0d", compares, errCount);
        if (errCount == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrapUp
    initial
    begin
        reset = 1'b1;
        {pllUnlock, eqFlag, drcFlag, powerFault, dcDetectEn, dcDetect} = '0;
        cyc(5);
        reset = 1'b0;
        cyc(5);
        testReset();
        testStatus();
        testControl();
        testErrors();
        testClockChange();
        wrapUp();
    end
    initial
    begin
        repeat (90000) @(posedge clk);
        errCount++;
        wrapUp();
    end
endmodule : audio_amp_ctrl_status_regs_tb_top
